// ===== ccsnp_pkg.sv
// constants and types for the capacitor code selector and its serial port
`default_nettype none
package ccsnp_pkg;
	localparam int          CODE_W        = 9;
	// slave address; the value is arbitrary
	localparam logic [6:0]  DEV_ID        = 7'h2A;
	// factory contents of the non-volatile store
	localparam logic [8:0]  NV_RESET_CODE = 9'h000;
	localparam logic [8:0]  VOL_RESET     = 9'h000;
	// command field inside the first configuration byte
	localparam int          CMD_LSB       = 6;
	localparam int          CMD_W         = 2;
	localparam logic [1:0]  CMD_WR_VOL    = 2'h0;
	localparam logic [1:0]  CMD_WR_NV     = 2'h1;
	localparam logic [1:0]  CMD_SET_NV    = 2'h2;
	localparam int          CODE_MSB_POS  = 0;
	// bit counter values inside one byte frame
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [3:0]  FRAME_BITS    = 4'h9;
	// programming interval
	localparam int          CLK_MHZ       = 250;
	localparam int          PROG_MIN_MS   = 4;
	localparam int          PROG_MAX_MS   = 8;
	localparam int          PROG_MIN_CYC  = PROG_MIN_MS * CLK_MHZ * 1000;
	localparam int          PROG_MAX_CYC  = PROG_MAX_MS * CLK_MHZ * 1000;
	localparam int          PROG_CNT_W    = 22;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ADDR   = 3'h1,
		ST_CFG1   = 3'h3,
		ST_CFG0   = 3'h2,
		ST_IGNORE = 3'h6
	} ccsnp_state_t;

	typedef struct packed {
		logic              nv_mode;
		logic [CODE_W-1:0] cap_code_word;
	} ccsnp_cap_t;
endpackage
`default_nettype wire

// ===== ccsnp_link_shift.sv
// serial-clock domain: shifts the data line in on each rising clock edge
`timescale 1ns/1ns
`default_nettype none
module ccsnp_link_shift (
	input  wire logic       scl_clk,
	input  wire logic       sda_in,
	output var  logic [7:0] link_byte
);
	import ccsnp_pkg::*;

	logic [7:0] shift_reg;
	logic [7:0] shift_next;

	// msb first; value holds still while the clock is low
	always_comb begin
		shift_next = {shift_reg[6:0], sda_in};
	end

	// no reset: this clock only runs inside frames
	always_ff @(posedge scl_clk) begin
		shift_reg <= shift_next;
	end

	assign link_byte = shift_reg;
endmodule // ccsnp_link_shift
`default_nettype wire

// ===== ccsnp_top.sv
// capacitor code selector with serial slave and non-volatile programming
`timescale 1ns/1ns
`default_nettype none
module ccsnp_top #(
	parameter int PROG_MIN = ccsnp_pkg::PROG_MIN_CYC,
	parameter int PROG_MAX = ccsnp_pkg::PROG_MAX_CYC
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               scl_clk,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output var  logic               sda_o,
	output var  logic               sda_oe_n,
	output var  logic               nv_busy,
	output var  ccsnp_pkg::ccsnp_cap_t cap_sel
);
	import ccsnp_pkg::*;

	logic [2:0]            scl_sync_reg, sda_sync_reg;
	logic [7:0]            link_byte;
	logic                  scl_rise, scl_fall, start_det, stop_det;
	ccsnp_state_t          state_reg, state_next;
	logic [3:0]            bit_reg, bit_next;
	logic [7:0]            cfg1_reg, cfg1_next;
	logic                  oe_n_reg, oe_n_next;
	logic [CODE_W-1:0]     vol_reg, vol_next;
	logic [CODE_W-1:0]     nv_store_reg, nv_store_next;
	logic [CODE_W-1:0]     prog_code_reg, prog_code_next;
	logic                  nv_mode_reg, nv_mode_next;
	logic                  prog_reg, prog_next;
	logic                  stop_seen_reg, stop_seen_next;
	logic [PROG_CNT_W-1:0] prog_cnt_reg, prog_cnt_next;
	ccsnp_cap_t            cap_reg, cap_next;
	logic                  acc, vol_wr, nv_set, prog_start, prog_done;
	logic [CODE_W-1:0]     rx_code;

	ccsnp_link_shift u_link (
		.scl_clk   (scl_clk),
		.sda_in    (sda_in),
		.link_byte (link_byte)
	);

	// two flops before use; third stage only feeds edge detection
	always_ff @(posedge clk) begin
		scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
		sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
	end

	// bus events seen from the synchronised pins
	assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
	assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
	assign start_det = scl_sync_reg[1] & scl_sync_reg[2] &
	                   ~sda_sync_reg[1] & sda_sync_reg[2];
	assign stop_det  = scl_sync_reg[1] & scl_sync_reg[2] &
	                   sda_sync_reg[1] & ~sda_sync_reg[2];
	assign rx_code   = {cfg1_reg[CODE_MSB_POS], link_byte};

	// protocol, mode select and programming start
	always_comb begin
		state_next     = state_reg;
		bit_next       = bit_reg;
		cfg1_next      = cfg1_reg;
		oe_n_next      = oe_n_reg;
		vol_next       = vol_reg;
		nv_mode_next   = nv_mode_reg;
		prog_code_next = prog_code_reg;
		acc            = 1'b0;
		vol_wr         = 1'b0;
		nv_set         = 1'b0;
		prog_start     = 1'b0;
		if (start_det) begin
			state_next = ST_ADDR;
			bit_next   = 4'h0;
			oe_n_next  = 1'b1;
		end else if (stop_det) begin
			state_next = ST_IDLE;
			bit_next   = 4'h0;
			oe_n_next  = 1'b1;
		end else if (scl_rise && state_reg != ST_IDLE) begin
			bit_next = bit_reg + 4'h1;
		end else if (scl_fall && state_reg != ST_IDLE) begin
			// link byte was shifted well before this fall, so it is stable
			if (bit_reg == BYTE_BITS) begin
				unique case (state_reg)
					ST_ADDR: begin
						// reads are not served; busy parts stay silent
						acc = link_byte[7:1] == DEV_ID && !link_byte[0]
						      && !prog_reg;
					end
					ST_CFG1: begin
						acc       = 1'b1;
						cfg1_next = link_byte;
					end
					ST_CFG0: begin
						acc = 1'b1;
						unique case (cfg1_reg[CMD_LSB +: CMD_W])
							CMD_WR_VOL: vol_wr = 1'b1;
							CMD_SET_NV: nv_set = 1'b1;
							CMD_WR_NV:  prog_code_next = rx_code;
							default:    acc = 1'b1;
						endcase
					end
					default: acc = 1'b0;
				endcase
				oe_n_next = ~acc;
			end else if (bit_reg == FRAME_BITS) begin
				oe_n_next = 1'b1;
				bit_next  = 4'h0;
				unique case (state_reg)
					ST_ADDR: state_next = oe_n_reg ? ST_IGNORE : ST_CFG1;
					ST_CFG1: state_next = ST_CFG0;
					default: state_next = ST_IGNORE;
				endcase
				// programming window opens at the fall after the ack
				prog_start = state_reg == ST_CFG0 && !oe_n_reg &&
				             cfg1_reg[CMD_LSB +: CMD_W] == CMD_WR_NV;
			end
		end
		if (vol_wr) begin
			vol_next     = rx_code;
			nv_mode_next = 1'b0;
		end
		if (nv_set)
			nv_mode_next = 1'b1;
	end

	// programming ends at stop once the least time is served, and at the longest time at the latest
	always_comb begin
		prog_next      = prog_reg;
		prog_cnt_next  = prog_cnt_reg;
		stop_seen_next = stop_seen_reg;
		nv_store_next  = nv_store_reg;
		prog_done      = prog_reg &&
		                 ((stop_seen_reg &&
		                   prog_cnt_reg >= PROG_CNT_W'(PROG_MIN - 1)) ||
		                  prog_cnt_reg >= PROG_CNT_W'(PROG_MAX - 1));
		if (prog_start) begin
			prog_next      = 1'b1;
			prog_cnt_next  = '0;
			stop_seen_next = 1'b0;
		end else if (prog_done) begin
			prog_next     = 1'b0;
			nv_store_next = prog_code_reg;
		end else if (prog_reg) begin
			prog_cnt_next = prog_cnt_reg + PROG_CNT_W'(1);
			if (stop_det)
				stop_seen_next = 1'b1;
		end
	end

	// the array follows whichever source the mode selects
	always_comb begin
		cap_next.nv_mode       = nv_mode_reg;
		cap_next.cap_code_word = nv_mode_reg ? nv_store_reg : vol_reg;
	end

	// reset stands for power-up; the store is reloaded with its factory contents
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			bit_reg       <= 4'h0;
			cfg1_reg      <= 8'h00;
			oe_n_reg      <= 1'b1;
			vol_reg       <= VOL_RESET;
			nv_mode_reg   <= 1'b1;
			prog_code_reg <= NV_RESET_CODE;
			nv_store_reg  <= NV_RESET_CODE;
			prog_reg      <= 1'b0;
			stop_seen_reg <= 1'b0;
			prog_cnt_reg  <= '0;
			cap_reg       <= {1'b1, NV_RESET_CODE};
		end else begin
			state_reg     <= state_next;
			bit_reg       <= bit_next;
			cfg1_reg      <= cfg1_next;
			oe_n_reg      <= oe_n_next;
			vol_reg       <= vol_next;
			nv_mode_reg   <= nv_mode_next;
			prog_code_reg <= prog_code_next;
			nv_store_reg  <= nv_store_next;
			prog_reg      <= prog_next;
			stop_seen_reg <= stop_seen_next;
			prog_cnt_reg  <= prog_cnt_next;
			cap_reg       <= cap_next;
		end
	end

	assign sda_o    = 1'b0; // open drain: only ever pulls low
	assign sda_oe_n = oe_n_reg;
	assign nv_busy  = prog_reg;
	assign cap_sel  = cap_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ack_fall;
		scl_fall && bit_reg == BYTE_BITS && acc;
	endsequence
	sequence s_prog_open;
		prog_start ##1 prog_reg;
	endsequence

	a_powerup_nv_mode: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> cap_reg.nv_mode && nv_mode_reg)
		else $error("not in stored-code mode after reset");
	a_vol_drive: assert property (!nv_mode_reg ##1 !nv_mode_reg
		|-> cap_reg.cap_code_word == $past(vol_reg))
		else $error("array not driven from volatile register");
	a_nv_drive: assert property (nv_mode_reg ##1 nv_mode_reg
		|-> cap_reg.cap_code_word == $past(nv_store_reg))
		else $error("array not driven from stored code");
	a_vol_code_full: assert property (vol_wr
		|=> vol_reg == $past(rx_code) ##1 !cap_reg.nv_mode)
		else $error("volatile write lost code or mode");
	a_prog_min_time: assert property ($fell(prog_reg) && !$past(rst)
		|-> $past(prog_cnt_reg) >= PROG_CNT_W'(PROG_MIN - 1))
		else $error("programming ended too early");
	a_prog_max_time: assert property (prog_reg
		|-> prog_cnt_reg < PROG_CNT_W'(PROG_MAX))
		else $error("programming ran past its longest time");
	a_prog_restart: assert property (s_prog_open
		|-> prog_cnt_reg == '0 && !stop_seen_reg)
		else $error("programming interval not started afresh");
	a_prog_at_fall: assert property ($rose(prog_reg)
		|-> $past(scl_fall) && $past(state_reg) == ST_CFG0)
		else $error("programming opened off the clock fall");
	a_sda_clk_low: assert property ($changed(oe_n_reg)
		|-> !$past(scl_sync_reg[1]) || $past(start_det || stop_det))
		else $error("data drive changed while clock high");
	a_ack_low: assert property (s_ack_fall
		|=> !sda_oe_n && sda_o == 1'b0)
		else $error("accepted byte not acknowledged");
	a_set_nv_mode: assert property (nv_set
		|=> nv_mode_reg ##1 cap_reg.nv_mode)
		else $error("mode command did not restore stored code");
endmodule // ccsnp_top
`default_nettype wire

// ===== ccsnp_bus_master.sv
// two-wire bus master model that issues write frames
`timescale 1ns/1ns
`default_nettype none
module ccsnp_bus_master (
	output var  logic scl,
	output var  logic sda_drv,
	input  wire logic sda
);
	// bus idles released; the clock stands still between frames
	initial begin
		scl     = 1'b1;
		sda_drv = 1'b1;
	end
	// one bit: data moves only while clock is low, read at the rise
	task automatic bit_x(input logic b, output logic s);
		#8 sda_drv = b;
		#24 scl = 1'b1;
		s = sda;
		#32 scl = 1'b0;
	endtask
	// start, three bytes with ack slots, optional stall, stop
	task automatic frame(input logic [23:0] d, input int stall,
		output logic [2:0] ack);
		logic s;
		// odd lead-in lets the bus phase drift against the system clock
		#17 sda_drv = 1'b0;
		#16 scl = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			bit_x(d[i], s);
			if (i % 8 == 0) begin
				bit_x(1'b1, s);
				ack[i / 8] = ~s;
			end
		end
		// a long stall holds the interval open until the stop, at most PROG_MAX cycles
		#(stall) sda_drv = 1'b0;
		#24 scl = 1'b1;
		#16 sda_drv = 1'b1;
		#16;
	endtask
endmodule // ccsnp_bus_master
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the capacitor code selector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ccsnp_pkg::*;
	// short counts keep the run brief; a frame still fits inside PMIN
	localparam int PMIN = 600;
	localparam int PMAX = 1200;
	logic        clk, rst, scl, sda_drv, sda_o, sda_oe_n, nv_busy, mode;
	ccsnp_cap_t  cap_sel;
	logic [31:0] rs;
	logic [8:0]  vol, nvc, v;
	logic [2:0]  ack;
	int          fail_count, cmp_count, busy_cnt, st, ex, tol;
	// open-drain line with pull-up
	// the device side counts only when its enable and its drive value agree
	wire logic sda = ((sda_oe_n === 1'b0 && sda_o === 1'b0) ||
	                  sda_drv === 1'b0) ? 1'b0 : 1'b1;
	ccsnp_top #(.PROG_MIN(PMIN), .PROG_MAX(PMAX)) dut_u (
		.clk(clk), .rst(rst), .scl_clk(scl), .scl_in(scl),
		.sda_in(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.nv_busy(nv_busy), .cap_sel(cap_sel));
	ccsnp_bus_master mst_u (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk_val(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_cap(input logic [9:0] g);
		logic [9:0] e;
		e = mode ? {1'b1, nvc} : {1'b0, vol};
		chk_val("cap_sel", {22'h0, e}, {22'h0, g});
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic send(input logic [7:0] a, input logic [1:0] c,
		input logic [8:0] d, input int stall, input logic [2:0] ea);
		mst_u.frame({a, c, 5'h00, d}, stall, ack);
		chk_val("ack", {29'h0, ea}, {29'h0, ack});
	endtask
	// master waits out programming before the next command
	task automatic wait_idle();
		int n;
		n = 0;
		while (nv_busy !== 1'b0 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 4000) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// count programming cycles away from the edge that launches the flag
	always @(negedge clk) if (nv_busy === 1'b1) busy_cnt++;
	// device drive must never move while the clock is high
	always @(sda_oe_n) begin
		if (scl === 1'b1 && rst === 1'b0)
			chk_val("oe_edge_scl_low", 32'h0, 32'h1);
	end
	// hang guard, far above the length of the run
	initial begin
		#300000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		rs = 32'h848E;
		mode = 1'b1;
		vol = VOL_RESET;
		nvc = NV_RESET_CODE;
		fail_count = 0;
		cmp_count = 0;
		busy_cnt = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk_cap(cap_sel);
		// volatile writes at both range ends, then random codes
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'(rnd());
			send({DEV_ID, 1'b0}, CMD_WR_VOL, v, 0, 3'h7);
			vol = v;
			mode = 1'b0;
			chk_cap(cap_sel);
		end
		// stored writes: stop at once, stop late, stop past the limit
		for (int i = 0; i < 3; i++) begin
			st = (i == 0) ? 0 : (i == 1) ? 3600 : 6000;
			v = 9'(rnd());
			busy_cnt = 0;
			send({DEV_ID, 1'b0}, CMD_WR_NV, v, st, 3'h7);
			chk_cap(cap_sel);
			if (i == 0)
				send({DEV_ID, 1'b0}, CMD_WR_VOL, 9'h0AA, 0, 3'h0);
			wait_idle();
			nvc = v;
			ex = (st + 40) / 4;
			ex = (ex < PMIN) ? PMIN : (ex > PMAX) ? PMAX : ex;
			tol = (i == 1) ? 24 : 3;
			chk_val("busy_len", 32'h1,
				{31'h0, busy_cnt >= ex - tol && busy_cnt <= ex + tol});
		end
		send({DEV_ID, 1'b0}, CMD_SET_NV, 9'h000, 0, 3'h7);
		mode = 1'b1;
		chk_cap(cap_sel);
		// foreign address, a read, an unknown command: nothing moves
		send({DEV_ID ^ 7'h01, 1'b0}, CMD_WR_VOL, 9'h155, 0, 3'h0);
		send({DEV_ID, 1'b1}, CMD_WR_VOL, 9'h155, 0, 3'h0);
		send({DEV_ID, 1'b0}, 2'h3, 9'h155, 0, 3'h7);
		chk_cap(cap_sel);
		send({DEV_ID, 1'b0}, CMD_WR_VOL, 9'h0F0, 0, 3'h7);
		vol = 9'h0F0;
		mode = 1'b0;
		chk_cap(cap_sel);
		// power cycle in mid-run returns to stored-code mode with the factory code
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		mode = 1'b1;
		nvc = NV_RESET_CODE;
		chk_cap(cap_sel);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
